// ==== verilog/underpower_pkg.sv ====
// constants, carriers and state codes for the directional under-power element
// assumes a 250 MHz system clock and phasor inputs scaled so nominal is 0x2000

package underpower_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_TICK_NS    = 32'h000F_4240;
  localparam int MS_CYCLES     = (MS_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_CNT_W      = 18;

  // ----------------------------------------------------------------
  // setting ranges and defaults
  // ----------------------------------------------------------------
  localparam logic signed [9:0] ANGLE_MIN = -10'sh0B3;
  localparam logic signed [9:0] ANGLE_MAX = 10'sh0B4;
  localparam logic signed [9:0] ANGLE_DEF = 10'sh000;
  localparam logic [11:0]       START_MIN = 12'h00A;
  localparam logic [11:0]       START_MAX = 12'h7D0;
  localparam logic [11:0]       START_DEF = 12'h064;
  localparam logic [15:0]       DELAY_MIN = 16'h00C8;
  localparam logic [15:0]       DELAY_MAX = 16'hEA60;
  localparam logic [15:0]       DELAY_DEF = 16'h00C8;

  // ----------------------------------------------------------------
  // arithmetic scaling
  // ----------------------------------------------------------------
  localparam int              NPHASE          = 3;
  localparam int              PQ_W            = 36;
  localparam int              PROJ_W          = 54;
  // three-phase power of one tenth of a percent of nominal (3 * 2^26 / 1000)
  localparam logic [17:0]     PCT_TENTH_POWER = 18'h3_126F;
  // reset ratio 1.05 as 269/256
  localparam logic [8:0]      HYST_NUM        = 9'h10D;
  localparam int              HYST_SHIFT      = 8;
  localparam logic [31:0]     TRIG_ONE_X4     = 32'h0001_0000;
  localparam logic [31:0]     BH_DEN          = 32'h0000_9E34;
  localparam logic signed [9:0] ANG_QUARTER   = 10'sh05A;
  localparam logic signed [9:0] ANG_FULL      = 10'sh168;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } phasor_t;

  typedef struct packed {
    phasor_t [NPHASE-1:0] u;
    phasor_t [NPHASE-1:0] i;
  } meas_t;

  typedef struct packed {
    logic signed [15:0] cos_v;
    logic signed [15:0] sin_v;
  } trig_t;

  typedef struct packed {
    logic start_chg;
    logic start_val;
    logic trip_chg;
    logic trip_val;
  } event_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_START = 3'b010,
    ST_TRIP  = 3'b100
  } state_t;

endpackage : underpower_pkg

// ==== verilog/setpoint_trig.sv ====
// cosine and sine of the direction angle, q14, registered
// assumes the angle setting is static; the divider is a long path settled by reset time

`timescale 1ns/100ps

module setpoint_trig (
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_n_in,
  input  wire logic signed [9:0]        angle_in,
  output underpower_pkg::trig_t         trig_out
);
  import underpower_pkg::*;

  // ----------------------------------------------------------------
  // sine by rational approximation, error well under one percent
  // ----------------------------------------------------------------
  function automatic logic signed [15:0] sin_q14(input logic signed [9:0] a);
    logic [9:0]  x;
    logic [31:0] t;
    logic [31:0] s;
    begin
      x = a[9] ? 10'($unsigned(-a)) : 10'($unsigned(a));
      t = 32'(x) * 32'(10'($unsigned(ANGLE_MAX)) - x);
      s = (TRIG_ONE_X4 * t) / (BH_DEN - t);
      sin_q14 = a[9] ? -$signed(16'(s)) : $signed(16'(s));
    end
  endfunction : sin_q14

  logic signed [9:0] shifted;
  logic signed [9:0] cos_angle;
  trig_t             trig_next;
  trig_t             trig_reg;

  // ----------------------------------------------------------------
  // setpoint direction
  // ----------------------------------------------------------------
  // unit vector of setpoint
  assign shifted         = angle_in + ANG_QUARTER;
  assign cos_angle       = (shifted > ANGLE_MAX) ? shifted - ANG_FULL : shifted;
  assign trig_next.cos_v = sin_q14(cos_angle);
  assign trig_next.sin_v = sin_q14(angle_in);

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      trig_reg <= '0;
    else
      trig_reg <= trig_next;
  end

  assign trig_out = trig_reg;

endmodule : setpoint_trig

// ==== verilog/under_power_element.sv ====
// directional under-power element: power calculation, directional line, delay, events
// assumes measurements arrive once per processing tick with a one-cycle valid strobe

`timescale 1ns/100ps

module under_power_element #(
  parameter int MS_CYCLES_P = underpower_pkg::MS_CYCLES
) (
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_n_in,
  input  underpower_pkg::meas_t         meas_in,
  input  wire logic                     meas_valid_in,
  input  wire logic                     operation_on_in,
  input  wire logic                     start_only_in,
  input  wire logic signed [9:0]        direction_angle_in,
  input  wire logic [11:0]              start_power_in,
  input  wire logic [15:0]              time_delay_in,
  input  wire logic                     block_in,
  input  wire logic                     vt_supervision_block_in,
  output logic                          general_pickup_out,
  output logic                          general_trip_out,
  output underpower_pkg::event_t        event_out
);
  import underpower_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // ----------------------------------------------------------------
  // settings; out-of-range values fall back to the default
  // ----------------------------------------------------------------
  logic signed [9:0] angle_eff;
  logic [11:0]       start_eff;
  logic [15:0]       delay_eff;

  assign angle_eff = (direction_angle_in < ANGLE_MIN || direction_angle_in > ANGLE_MAX) ?
                     ANGLE_DEF : direction_angle_in;
  assign start_eff = (start_power_in < START_MIN || start_power_in > START_MAX) ?
                     START_DEF : start_power_in;
  assign delay_eff = (time_delay_in < DELAY_MIN || time_delay_in > DELAY_MAX) ?
                     DELAY_DEF : time_delay_in;

  // ----------------------------------------------------------------
  // power calculation
  // ----------------------------------------------------------------
  logic signed [PQ_W-1:0] p_ph [NPHASE];
  logic signed [PQ_W-1:0] q_ph [NPHASE];
  logic signed [PQ_W-1:0] p_reg;
  logic signed [PQ_W-1:0] q_reg;
  logic                   pq_valid_reg;

  // per-phase s = u * conj(i)
  for (genvar g = 0; g < NPHASE; g++)
  begin : g_phase
    assign p_ph[g] = PQ_W'(meas_in.u[g].re * meas_in.i[g].re)
                   + PQ_W'(meas_in.u[g].im * meas_in.i[g].im);
    assign q_ph[g] = PQ_W'(meas_in.u[g].im * meas_in.i[g].re)
                   - PQ_W'(meas_in.u[g].re * meas_in.i[g].im);
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p_reg        <= '0;
      q_reg        <= '0;
      pq_valid_reg <= 1'b0;
    end
    else
    begin
      pq_valid_reg <= meas_valid_in;
      if (meas_valid_in)
      begin
        p_reg <= p_ph[0] + p_ph[1] + p_ph[2];
        q_reg <= q_ph[0] + q_ph[1] + q_ph[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // directional decision
  // ----------------------------------------------------------------
  trig_t                    trig;
  logic signed [PROJ_W-1:0] proj;
  logic [29:0]              thr_pct;
  logic [38:0]              hyst_mul;
  logic [30:0]              thr_sel;
  logic signed [PROJ_W-1:0] thr_cmp;
  logic                     dir_hit;
  logic                     base_hit;
  logic                     dir_pick_reg;

  setpoint_trig u_trig (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n),
    .angle_in   (angle_eff),
    .trig_out   (trig)
  );

  // distance of the point along the setpoint direction
  assign proj     = PROJ_W'(p_reg) * PROJ_W'(trig.cos_v) + PROJ_W'(q_reg) * PROJ_W'(trig.sin_v);
  assign thr_pct  = 30'(start_eff) * 30'(PCT_TENTH_POWER);
  assign hyst_mul = 39'(thr_pct) * 39'(HYST_NUM);
  assign thr_sel  = dir_pick_reg ? hyst_mul[38:HYST_SHIFT] : {1'b0, thr_pct};
  assign thr_cmp  = $signed({9'h000, thr_sel, 14'h0000});
  // origin side of the line, i.e. projection below the start power threshold, or below 269/256 of it while picked up
  assign dir_hit  = proj < thr_cmp;
  assign base_hit = proj < $signed({9'h000, 1'b0, thr_pct, 14'h0000});

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
      dir_pick_reg <= 1'b0;
    else if (pq_valid_reg)
      dir_pick_reg <= dir_hit;
  end

  // ----------------------------------------------------------------
  // millisecond tick and start/trip sequence
  // ----------------------------------------------------------------
  localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(MS_CYCLES_P - 1);

  logic [MS_CNT_W-1:0] tick_cnt_reg;
  logic                ms_tick;
  logic [15:0]         ms_cnt_reg;
  logic [15:0]         ms_cnt_next;
  logic                start_cond;
  logic                timer_done;
  state_t              state_reg;
  state_t              state_next;

  assign ms_tick = (tick_cnt_reg == MS_LAST);

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= ms_tick ? '0 : tick_cnt_reg + MS_CNT_W'(1);
  end

  // pickup gated by both block inputs
  assign start_cond = operation_on_in & dir_pick_reg & ~block_in & ~vt_supervision_block_in;
  // tick phase is unknown at start, so the delay lands between d and d+1 ms
  assign timer_done = ms_tick && (ms_cnt_reg == delay_eff);

  always_comb
  begin
    state_next = ST_IDLE;
    case (state_reg)
      ST_IDLE:
        state_next = start_cond ? ST_START : ST_IDLE;
      ST_START:
        if (!start_cond)
          state_next = ST_IDLE;
        else if (!start_only_in && timer_done)
          state_next = ST_TRIP;
        else
          state_next = ST_START;
      ST_TRIP:
        if (!start_cond)
          state_next = ST_IDLE;
        else if (start_only_in)
          state_next = ST_START;
        else
          state_next = ST_TRIP;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // timer cleared whenever start drops; saturates at the delay
  assign ms_cnt_next = (state_next == ST_IDLE) ? 16'h0000 :
                       (ms_tick && ms_cnt_reg < delay_eff) ? ms_cnt_reg + 16'h0001 :
                       ms_cnt_reg;

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg  <= ST_IDLE;
      ms_cnt_reg <= 16'h0000;
    end
    else
    begin
      state_reg  <= state_next;
      ms_cnt_reg <= ms_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs and events
  // ----------------------------------------------------------------
  logic   pickup_next;
  logic   trip_next;
  event_t event_next;

  assign pickup_next = (state_next != ST_IDLE);
  assign trip_next   = (state_next == ST_TRIP);
  // change of state with new value
  assign event_next  = '{start_chg: pickup_next != general_pickup_out, start_val: pickup_next,
                         trip_chg:  trip_next != general_trip_out,     trip_val:  trip_next};

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      general_pickup_out <= 1'b0;
      general_trip_out   <= 1'b0;
      event_out          <= '0;
    end
    else
    begin
      general_pickup_out <= pickup_next;
      general_trip_out   <= trip_next;
      event_out          <= event_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n);

  a_dir_threshold: assert property (
    pq_valid_reg && !dir_pick_reg && (proj < thr_cmp) |=> dir_pick_reg)
    else $error("pickup missed below threshold");
  a_hyst_hold: assert property (
    pq_valid_reg && dir_pick_reg && !base_hit && dir_hit |=> dir_pick_reg)
    else $error("pickup dropped inside hysteresis band");
  a_start_gated: assert property (
    general_pickup_out |-> $past(dir_pick_reg) && !$past(block_in)
      && !$past(vt_supervision_block_in))
    else $error("start without pickup or while blocked");
  a_vts_blocks: assert property (
    vt_supervision_block_in |=> !general_pickup_out && !general_trip_out)
    else $error("outputs active under supervision block");
  a_trip_delay: assert property (
    $rose(general_trip_out) |-> $past(ms_cnt_reg) == $past(delay_eff) && $past(ms_tick)
      && general_pickup_out)
    else $error("trip not at delay expiry");
  a_start_only: assert property (
    start_only_in |=> !general_trip_out)
    else $error("trip issued in start-only mode");
  a_timer_clear: assert property (
    $fell(general_pickup_out) |-> ms_cnt_reg == 16'h0000 && !general_trip_out)
    else $error("timer or trip survived start drop");
  a_off_quiet: assert property (
    !operation_on_in |=> !general_pickup_out ##0 !general_trip_out)
    else $error("outputs active with operation off");
  a_start_event: assert property (
    $changed(general_pickup_out) |-> event_out.start_chg
      && event_out.start_val == general_pickup_out)
    else $error("start change without event");
  a_trip_event: assert property (
    event_out.trip_chg |-> $changed(general_trip_out) && event_out.trip_val == general_trip_out)
    else $error("trip event without trip change");
  c_trip_rise: cover property ($rose(general_trip_out));
  c_start_only: cover property (start_only_in && general_pickup_out [*8]);
  c_hyst_held: cover property (pq_valid_reg && dir_pick_reg && !base_hit ##1 dir_pick_reg);
  c_vts_drop: cover property (general_pickup_out ##1 vt_supervision_block_in);

endmodule : under_power_element

// ==== tb/meas_source.sv ====
// measurement front end model: nominal voltages, bench-chosen currents
// assumes one strobe every TICK_P cycles and raw reset from the bench

`timescale 1ns/100ps

module meas_source #(
  parameter int TICK_P = 8
) (
  input  wire logic                clk_sys_in,
  input  wire logic                rst_n_in,
  input  wire logic signed [15:0]  ire_in,
  input  wire logic signed [15:0]  iim_in,
  output underpower_pkg::meas_t    meas_out,
  output logic                     meas_valid_out
);
  import underpower_pkg::*;

  logic [7:0] tick_cnt_reg;
  logic       tick_last;
  meas_t      frame_next;

  // ----------------------------------------------------------------
  // frame and strobe
  // ----------------------------------------------------------------
  assign tick_last = (tick_cnt_reg == 8'(TICK_P - 1));

  always_comb
  begin
    for (int k = 0; k < NPHASE; k++)
    begin
      frame_next.u[k] = '{re: 16'sh2000, im: 16'sh0000};
      frame_next.i[k] = '{re: ire_in, im: iim_in};
    end
  end

  // one strobe per tick
  // between strobes the bus shows the inverse, so stale data is never read by luck
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tick_cnt_reg   <= 8'h00;
      meas_valid_out <= 1'b0;
      meas_out       <= '0;
    end
    else
    begin
      tick_cnt_reg   <= tick_last ? 8'h00 : tick_cnt_reg + 8'h01;
      meas_valid_out <= tick_last;
      meas_out       <= tick_last ? frame_next : ~frame_next;
    end
  end
endmodule : meas_source

// ==== tb/under_power_element_tb_top.sv ====
// self-checking bench for the directional under-power element
// assumes 1 ms is shortened to MS_P cycles and a strobe comes every 8 cycles

`timescale 1ns/100ps

module under_power_element_tb_top;
  import underpower_pkg::*;

  localparam int MS_P = 10;

  typedef struct packed {
    logic signed [9:0]  ang;
    logic [11:0]        pwr;
    logic signed [15:0] ire;
    logic signed [15:0] iim;
    logic [2:0]         obv;
    logic               pick;
  } row_t;

  logic               clk_sys_in = 1'b0;
  logic               rst_n      = 1'b0;
  logic               op         = 1'b0;
  logic               only       = 1'b0;
  logic signed [9:0]  ang        = ANGLE_DEF;
  logic [11:0]        pwr        = START_DEF;
  logic [15:0]        dly        = DELAY_DEF;
  logic               blk        = 1'b0;
  logic               vt_supervision_block        = 1'b0;
  logic signed [15:0] ire        = 16'sh0000;
  logic signed [15:0] iim        = 16'sh0000;
  logic               pick_q     = 1'b0;
  logic               trip_q     = 1'b0;
  meas_t              meas;
  logic               meas_valid;
  logic               general_pickup_out;
  logic               general_trip_out;
  event_t             event_out;
  int                 n_fail     = 0;
  int                 checks     = 0;
  int                 n;

  // ----------------------------------------------------------------
  // cases: angle, start power, current re/im, {on, block, vt block}, pickup
  // ----------------------------------------------------------------
  // 400 = 4.9 %, 600 = 7.3 %, 840 = 10.25 %, 2000 = 24.4 % of nominal
  row_t rows [18] = '{
    '{ANGLE_DEF, START_DEF, 16'sh0190, 16'sh0000, 3'b100, 1'b1},
    '{ANGLE_DEF, START_DEF, 16'sh07D0, 16'sh0000, 3'b100, 1'b0},
    '{ANG_QUARTER, START_DEF, 16'sh07D0, 16'sh0000, 3'b100, 1'b1},
    '{ANG_QUARTER, START_DEF, 16'sh0000, -16'sh07D0, 3'b100, 1'b0},
    '{ANGLE_MAX, START_DEF, 16'sh07D0, 16'sh0000, 3'b100, 1'b1},
    '{ANGLE_MAX, START_DEF, -16'sh07D0, 16'sh0000, 3'b100, 1'b0},
    '{-ANG_QUARTER, START_DEF, 16'sh0000, 16'sh07D0, 3'b100, 1'b0},
    '{ANGLE_DEF, START_MAX, 16'sh3000, 16'sh0000, 3'b100, 1'b1},
    '{ANGLE_DEF, START_MIN, 16'sh0258, 16'sh0000, 3'b100, 1'b0},
    '{ANGLE_DEF, 12'h005, 16'sh0258, 16'sh0000, 3'b100, 1'b1},
    '{ANGLE_DEF, START_DEF, 16'sh0190, 16'sh0000, 3'b110, 1'b0},
    '{ANGLE_DEF, START_DEF, 16'sh0190, 16'sh0000, 3'b101, 1'b0},
    '{ANGLE_DEF, START_DEF, 16'sh0190, 16'sh0000, 3'b000, 1'b0},
    '{10'sh0C8, START_DEF, 16'sh0190, 16'sh0000, 3'b100, 1'b1},
    '{ANGLE_DEF, START_DEF, 16'sh07D0, 16'sh0000, 3'b100, 1'b0},
    '{ANGLE_DEF, START_DEF, 16'sh0348, 16'sh0000, 3'b100, 1'b0},
    '{ANGLE_DEF, START_DEF, 16'sh0190, 16'sh0000, 3'b100, 1'b1},
    '{ANGLE_DEF, START_DEF, 16'sh0348, 16'sh0000, 3'b100, 1'b1}
  };
  logic [15:0] dly_set [4] = '{16'h00C8, 16'h012C, 16'h0064, 16'h00C8};
  int          dly_eff [4] = '{200, 300, 200, 200};

  always #2 clk_sys_in = ~clk_sys_in;

  meas_source meas_source_i (
    .clk_sys_in     (clk_sys_in),
    .rst_n_in       (rst_n),
    .ire_in         (ire),
    .iim_in         (iim),
    .meas_out       (meas),
    .meas_valid_out (meas_valid)
  );

  under_power_element #(.MS_CYCLES_P(MS_P)) under_power_element_i (
    .clk_sys_in              (clk_sys_in),
    .rst_n_in                (rst_n),
    .meas_in                 (meas),
    .meas_valid_in           (meas_valid),
    .operation_on_in         (op),
    .start_only_in           (only),
    .direction_angle_in      (ang),
    .start_power_in          (pwr),
    .time_delay_in           (dly),
    .block_in                (blk),
    .vt_supervision_block_in (vt_supervision_block),
    .general_pickup_out      (general_pickup_out),
    .general_trip_out        (general_trip_out),
    .event_out               (event_out)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic exp, input logic got);
    checks = checks + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check

  // settles over two strobes plus the pipeline before the caller looks
  task automatic drive(input row_t r);
    @(posedge clk_sys_in);
    ang <= r.ang;
    pwr <= r.pwr;
    ire <= r.ire;
    iim <= r.iim;
    {op, blk, vt_supervision_block} <= r.obv;
    repeat (24) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask : drive

  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  // every change of an output must come with its event in that cycle
  always @(negedge clk_sys_in)
  begin
    if (rst_n)
    begin
      check("start event", general_pickup_out !== pick_q, event_out.start_chg);
      check("trip event", general_trip_out !== trip_q, event_out.trip_chg);
      if (event_out.start_chg === 1'b1)
        check("start event value", ~pick_q, event_out.start_val);
      if (event_out.trip_chg === 1'b1)
        check("trip event value", ~trip_q, event_out.trip_val);
    end
    pick_q = general_pickup_out;
    trip_q = general_trip_out;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    rst_n <= 1'b1;
    @(negedge clk_sys_in);
    check("pickup after reset", 1'b0, general_pickup_out);
    check("trip after reset", 1'b0, general_trip_out);
    foreach (rows[k])
    begin
      drive(rows[k]);
      check($sformatf("pickup row %0d", k), rows[k].pick, general_pickup_out);
    end
    foreach (dly_set[k])
    begin
      drive(rows[1]);
      @(posedge clk_sys_in);
      dly  <= dly_set[k];
      only <= (k == 3);
      ire  <= 16'sh0190;
      n = 0;
      while (general_pickup_out !== 1'b1 && n < 40)
      begin
        @(posedge clk_sys_in);
        n = n + 1;
      end
      n = 0;
      while (general_trip_out !== 1'b1 && n < (dly_eff[k] + 2) * MS_P)
      begin
        @(posedge clk_sys_in);
        n = n + 1;
      end
      @(negedge clk_sys_in);
      if (k == 3)
      begin
        check("trip held off", 1'b0, general_trip_out);
        check("start kept", 1'b1, general_pickup_out);
      end
      else
        check($sformatf("trip delay %0d", n), 1'b1,
              n >= dly_eff[k] * MS_P - 1 && n <= (dly_eff[k] + 1) * MS_P + 2);
      @(posedge clk_sys_in);
      blk <= 1'b1;
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      check("pickup dropped", 1'b0, general_pickup_out);
      check("trip dropped", 1'b0, general_trip_out);
      @(posedge clk_sys_in);
      blk <= 1'b0;
    end
    // ----------------------------------------------------------------
    // hand-written cases: start-only toggled, supervision block, reset
    // ----------------------------------------------------------------
    // start-only still set here; the timer runs out and saturates
    drive(rows[0]);
    repeat ((dly_eff[0] + 1) * MS_P) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check("trip under start-only", 1'b0, general_trip_out);
    @(posedge clk_sys_in);
    only <= 1'b0;
    // saturated timer trips on the next ms tick
    repeat (MS_P + 1) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check("trip after start-only lifted", 1'b1, general_trip_out);
    @(posedge clk_sys_in);
    only <= 1'b1;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check("trip withdrawn by start-only", 1'b0, general_trip_out);
    check("start kept by start-only", 1'b1, general_pickup_out);
    @(posedge clk_sys_in);
    vt_supervision_block <= 1'b1;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check("pickup under supervision block", 1'b0, general_pickup_out);
    @(posedge clk_sys_in);
    vt_supervision_block <= 1'b0;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check("pickup before mid-run reset", 1'b1, general_pickup_out);
    @(posedge clk_sys_in);
    rst_n <= 1'b0;
    @(negedge clk_sys_in);
    check("pickup in mid-run reset", 1'b0, general_pickup_out);
    repeat (8) @(posedge clk_sys_in);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check("pickup at reset release", 1'b0, general_pickup_out);
    check("trip at reset release", 1'b0, general_trip_out);
    // the front end restarts too, so the decision waits for a fresh strobe
    repeat (24) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check("pickup on first strobe", 1'b1, general_pickup_out);
    give_verdict();
  end

  // cut a hang well past the longest expected run
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    n_fail = n_fail + 1;
    give_verdict();
  end
endmodule : under_power_element_tb_top
